/* File: verilog/lgt_pkg.sv */
// Package for the loop guard timer: register offsets, field layout, reset values, timing.
// Assumes a single 40 MHz system clock and a plain strobe register port.
`default_nettype none

package lgt_pkg;

  localparam logic [1:0] LGT_ADDR_MODE = 2'h0;
  localparam logic [1:0] LGT_ADDR_CLEAR = 2'h1;
  localparam logic [1:0] LGT_ADDR_STAT = 2'h2;
  localparam logic [1:0] LGT_ADDR_MASK = 2'h3;

  localparam logic [7:0] LGT_MODE_RESET = 8'h67;
  localparam logic [7:0] LGT_CLEAR_KEY = 8'hac;
  localparam logic [7:0] LGT_CLEAR_READ = 8'h9a;
  localparam logic [2:0] LGT_MODE_TOP = 3'h3;

  localparam int LGT_IVL_LSB = 0;
  localparam int LGT_CSEL_LSB = 3;
  localparam int LGT_SLOW_BASE = 11;
  localparam int LGT_SYS_BASE = 13;
  localparam int LGT_CNT_W = 21;

  // Event bits of the status register
  localparam int LGT_EV_OVF = 0;
  localparam int LGT_EV_MODE2 = 1;
  localparam int LGT_EV_BADKEY = 2;
  localparam int LGT_EV_W = 3;

  localparam int LGT_CLK_HZ = 40000000;
  localparam int LGT_STOP_IDLE_NS = 34000;
  localparam int LGT_STOP_IDLE_CYC = LGT_STOP_IDLE_NS / (1000000000 / LGT_CLK_HZ);

  typedef enum logic [1:0] {
    LGT_SRC_SLOW = 2'b00,
    LGT_SRC_SYS = 2'b01,
    LGT_SRC_OFF = 2'b10
  } lgt_src_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic bitop;
  } lgt_bus_t;

endpackage : lgt_pkg

`default_nettype wire

/* File: verilog/lgt_sync.sv */
// Two-flop synchroniser for one asynchronous level.
// Assumes the destination clock is sys_clk.
`default_nettype none

module lgt_sync
  import lgt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_ff <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule : lgt_sync

`default_nettype wire

/* File: verilog/lgt_loop_guard_timer.sv */
// Loop guard timer: mode/clear registers, counter, internal reset request, event interrupt.
// Assumes slow_internal_clk, halt, stop and option are asynchronous pins; bus on sys_clk.
//
// Local design decisions: the address-and-strobe port and the register offsets.
`default_nettype none

module lgt_loop_guard_timer
  import lgt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_bitop,
  output logic [7:0] reg_rdata,
  input wire logic slow_internal_clk,
  input wire logic osc_unstoppable,
  input wire logic halt_mode,
  input wire logic stop_mode,
  output logic internal_rst_req,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic slow_s;
  logic unstop_s;
  logic halt_s;
  logic stop_s;

  lgt_sync u_sync_slow (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(slow_internal_clk),
    .sync_out(slow_s)
  );
  lgt_sync u_sync_opt (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(osc_unstoppable),
    .sync_out(unstop_s)
  );
  lgt_sync u_sync_halt (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(halt_mode),
    .sync_out(halt_s)
  );
  lgt_sync u_sync_stop (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(stop_mode),
    .sync_out(stop_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  lgt_bus_t bus;
  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd, bitop: reg_bitop};

  logic mode_wr;
  logic clear_wr;
  logic stat_rd;
  assign mode_wr = bus.wr && (bus.addr == LGT_ADDR_MODE);
  assign clear_wr = bus.wr && (bus.addr == LGT_ADDR_CLEAR);
  assign stat_rd = bus.rd && (bus.addr == LGT_ADDR_STAT);

  ////////////////////////////////////////////////////////////////////////
  // Mode register, write-once tracking

  logic [7:0] mode_ff;
  logic written_ff;
  logic disarmed_ff;
  logic [1:0] wr_csel;
  logic first_wr;
  assign wr_csel = bus.wdata[LGT_CSEL_LSB+1:LGT_CSEL_LSB];
  assign first_wr = mode_wr && !written_ff && !bus.bitop;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_ff <= LGT_MODE_RESET;
    end else if (first_wr) begin
      mode_ff[7:5] <= LGT_MODE_TOP;
      mode_ff[2:0] <= bus.wdata[2:0];
      if (unstop_s) begin
        mode_ff[4:3] <= LGT_SRC_SLOW;
      end else begin
        mode_ff[4:3] <= wr_csel;
      end
    end
  end

  // A rejected single-bit write does not use up the one mode write
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      written_ff <= 1'b0;
    end else if (first_wr) begin
      written_ff <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      disarmed_ff <= 1'b0;
    end else if (first_wr) begin
      disarmed_ff <= !unstop_s && wr_csel[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock source decode and pause control

  lgt_src_t src;
  always_comb begin
    if (unstop_s) begin
      src = LGT_SRC_SLOW;
    end else begin
      case (mode_ff[4:3])
        2'b00: src = LGT_SRC_SLOW;
        2'b01: src = LGT_SRC_SYS;
        default: src = LGT_SRC_OFF;
      endcase
    end
  end

  localparam logic [11:0] IDLE_CYC = 12'(LGT_STOP_IDLE_CYC);

  typedef enum logic [1:0] {
    LGT_PH_RUN = 2'b00,
    LGT_PH_HALT = 2'b01,
    LGT_PH_STOP = 2'b10,
    LGT_PH_WAKE = 2'b11
  } lgt_phase_t;

  lgt_phase_t phase_ff;
  lgt_phase_t nxt_phase;
  logic [11:0] idle_ff;
  logic [11:0] nxt_idle;

  // Low-power phases only matter when the oscillator may be stopped
  always_comb begin
    nxt_phase = phase_ff;
    nxt_idle = idle_ff;
    case (phase_ff)
      LGT_PH_RUN: begin
        if (!unstop_s && stop_s) begin
          nxt_phase = LGT_PH_STOP;
        end else if (!unstop_s && halt_s) begin
          nxt_phase = LGT_PH_HALT;
        end
      end
      LGT_PH_HALT: begin
        if (unstop_s) begin
          nxt_phase = LGT_PH_RUN;
        end else if (stop_s) begin
          nxt_phase = LGT_PH_STOP;
        end else if (!halt_s) begin
          nxt_phase = LGT_PH_RUN;
        end
      end
      LGT_PH_STOP: begin
        if (unstop_s) begin
          nxt_phase = LGT_PH_RUN;
        end else if (!stop_s) begin
          nxt_phase = LGT_PH_WAKE;
          nxt_idle = IDLE_CYC - 12'h001;
        end
      end
      LGT_PH_WAKE: begin
        if (unstop_s) begin
          nxt_phase = LGT_PH_RUN;
          nxt_idle = 12'h000;
        end else if (stop_s) begin
          nxt_phase = LGT_PH_STOP;
          nxt_idle = 12'h000;
        end else if (idle_ff <= 12'h001) begin
          nxt_phase = LGT_PH_RUN;
          nxt_idle = 12'h000;
        end else begin
          nxt_idle = idle_ff - 12'h001;
        end
      end
      default: begin
        nxt_phase = LGT_PH_RUN;
        nxt_idle = 12'h000;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_ff <= LGT_PH_RUN;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idle_ff <= 12'h000;
    end else begin
      idle_ff <= nxt_idle;
    end
  end

  // The LGT_STOP_IDLE_NS wake-up time after STOP stays paused as well
  logic waking;
  assign waking = (phase_ff == LGT_PH_STOP) || (phase_ff == LGT_PH_WAKE);

  logic paused;
  assign paused = !unstop_s && (halt_s || stop_s || waking);

  ////////////////////////////////////////////////////////////////////////
  // Counter and overflow

  logic slow_prev_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      slow_prev_ff <= 1'b0;
    end else begin
      slow_prev_ff <= slow_s;
    end
  end

  logic tick;
  always_comb begin
    case (src)
      LGT_SRC_SLOW: tick = slow_s && !slow_prev_ff;
      LGT_SRC_SYS: tick = 1'b1;
      default: tick = 1'b0;
    endcase
  end

  logic [LGT_CNT_W-1:0] cnt_ff;
  logic [LGT_CNT_W-1:0] limit;
  logic [4:0] shift;
  always_comb begin
    if (src == LGT_SRC_SYS) begin
      shift = 5'(LGT_SYS_BASE) + {2'b00, mode_ff[2:0]};
    end else begin
      shift = 5'(LGT_SLOW_BASE) + {2'b00, mode_ff[2:0]};
    end
    limit = LGT_CNT_W'(1) << shift;
  end

  logic key_ok;
  assign key_ok = clear_wr && !bus.bitop && (bus.wdata == LGT_CLEAR_KEY);

  logic ovf;
  assign ovf = tick && !paused && !mode_wr && !key_ok && (cnt_ff + LGT_CNT_W'(1) >= limit);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (mode_wr || key_ok) begin
      cnt_ff <= '0;
    end else if (ovf) begin
      cnt_ff <= '0;
    end else if (tick && !paused) begin
      cnt_ff <= cnt_ff + LGT_CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Internal reset request

  logic bad_mode;
  logic bad_key;
  assign bad_mode = mode_wr && (written_ff || bus.bitop) && !disarmed_ff;
  assign bad_key = clear_wr && !key_ok && !disarmed_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      internal_rst_req <= 1'b0;
    end else begin
      internal_rst_req <= ovf || bad_mode || bad_key;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event status, mask, interrupt

  logic [LGT_EV_W-1:0] ev;
  logic [LGT_EV_W-1:0] stat_ff;
  logic [LGT_EV_W-1:0] mask_ff;
  logic [LGT_EV_W-1:0] nxt_stat;
  logic [LGT_EV_W-1:0] nxt_mask;
  logic mask_wr;
  assign ev = {bad_key, bad_mode, ovf};
  assign mask_wr = bus.wr && (bus.addr == LGT_ADDR_MASK);

  // Read clears, but an event in the same cycle stays set
  always_comb begin
    if (stat_rd) begin
      nxt_stat = ev;
    end else begin
      nxt_stat = stat_ff | ev;
    end
  end

  always_comb begin
    if (mask_wr) begin
      nxt_mask = bus.wdata[LGT_EV_W-1:0];
    end else begin
      nxt_mask = mask_ff;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_ff <= '0;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(nxt_stat & nxt_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        LGT_ADDR_MODE: reg_rdata <= mode_ff;
        LGT_ADDR_CLEAR: reg_rdata <= LGT_CLEAR_READ;
        LGT_ADDR_STAT: reg_rdata <= {5'h00, stat_ff};
        LGT_ADDR_MASK: reg_rdata <= {5'h00, mask_ff};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : lgt_loop_guard_timer

`default_nettype wire

/* File: sim/lgt_sw_model.sv */
// Software side: register writes and reads on the strobe port.
// Assumes read data stand in the cycle after the read strobe.
`default_nettype none
module lgt_sw_model
  import lgt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  output logic [1:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic reg_bitop
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd, reg_bitop} = '0;
  task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic b);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_bitop <= b;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_bitop <= 1'b0;
  endtask : wr
  task automatic wr_mode(input logic [4:0] f);
    wr(LGT_ADDR_MODE, {3'b011, f}, 1'b0);
  endtask : wr_mode
  task automatic rd(input logic [1:0] a, output logic [7:0] q);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    q = reg_rdata;
  endtask : rd
endmodule : lgt_sw_model
`default_nettype wire

/* File: sim/lgt_chk.sv */
// Port checker for the loop guard timer, bound at the foot.
// Assumes the option pin holds steady after reset.
`default_nettype none
module lgt_chk
  import lgt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_bitop,
  input wire logic [7:0] reg_rdata,
  input wire logic osc_unstoppable,
  input wire logic internal_rst_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic mw_ff, dis_ff;
  wire logic mw = reg_wr && reg_addr == LGT_ADDR_MODE && !reg_bitop;
  wire logic cw = reg_wr && reg_addr == LGT_ADDR_CLEAR;
  wire logic bad = cw && (reg_bitop || reg_wdata != 8'hac);
  wire logic rm = reg_rd && reg_addr == LGT_ADDR_MODE;
  // First mode write and whether it halted the timer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mw_ff <= 1'b0;
      dis_ff <= 1'b0;
    end else if (mw && !mw_ff) begin
      mw_ff <= 1'b1;
      dis_ff <= reg_wdata[4] & ~osc_unstoppable;
    end
  end
  property p_rk; reg_rd && reg_addr == LGT_ADDR_CLEAR |=> reg_rdata == 8'h9a; endproperty
  a_rk: assert property (p_rk) else $error("clear read value");
  property p_bad; bad && !dis_ff |=> internal_rst_req; endproperty
  a_bad: assert property (p_bad) else $error("bad key no reset");
  property p_ok; cw && !bad |=> !internal_rst_req; endproperty
  a_ok: assert property (p_ok) else $error("good key reset");
  property p_m2; mw && mw_ff && !dis_ff |=> internal_rst_req; endproperty
  a_m2: assert property (p_m2) else $error("second mode write");
  property p_dis; reg_wr && dis_ff |=> !internal_rst_req; endproperty
  a_dis: assert property (p_dis) else $error("reset while halted");
  property p_rv; rm && !mw_ff |=> reg_rdata == 8'h67; endproperty
  a_rv: assert property (p_rv) else $error("mode reset value");
  property p_cs; rm && osc_unstoppable |=> reg_rdata[4:3] == 2'b00; endproperty
  a_cs: assert property (p_cs) else $error("clock select kept");
  property p_pl; $rose(internal_rst_req) |=> !internal_rst_req; endproperty
  a_pl: assert property (p_pl) else $error("reset pulse long");
endmodule : lgt_chk
bind lgt_loop_guard_timer lgt_chk i_lgt_chk (.sys_clk(sys_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_bitop(reg_bitop), .reg_rdata(reg_rdata), .osc_unstoppable(osc_unstoppable),
  .internal_rst_req(internal_rst_req));
`default_nettype wire

/* File: sim/tb_lgt_loop_guard_timer.sv */
// Bench for the loop guard timer: options, keys, overflow timing, low power.
// Assumes the software model and checker are compiled before it.
`default_nettype none
module tb_lgt_loop_guard_timer
  import lgt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst, slow_clk, osc, halt_m, stop_m, req, irq, wr, rd, bop;
  logic [1:0] a;
  logic [7:0] wd, rdat, q;
  logic [31:0] lf;
  int err_total, n_checks, n, e;
  lgt_loop_guard_timer i_lgt_loop_guard_timer (.sys_clk(sys_clk), .rst(rst), .reg_addr(a),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_bitop(bop), .reg_rdata(rdat),
    .slow_internal_clk(slow_clk), .osc_unstoppable(osc), .halt_mode(halt_m),
    .stop_mode(stop_m), .internal_rst_req(req), .irq(irq));
  lgt_sw_model i_lgt_sw_model (.sys_clk(sys_clk), .reg_rdata(rdat), .reg_addr(a),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_bitop(bop));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    slow_clk = 1'b0;
    #7;
    forever #100 slow_clk = ~slow_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      err_total++;
      $display("MISMATCH %s exp %0h got %0h", s, x, g);
    end
  endtask : chk
  task automatic near(input string s, input int x);
    n_checks++;
    if (n < x - 12 || n > x + 12) begin
      err_total++;
      $display("MISMATCH %s exp %0d got %0d", s, x, n);
    end
  endtask : near
  task automatic wait_req(input int cap);
    n = 0;
    while (req !== 1'b1 && n < cap) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask : wait_req
  task automatic do_reset(input logic o);
    {osc, halt_m, stop_m} <= {o, 2'b00};
    rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : do_reset
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, osc, halt_m, stop_m} = 4'h8;
    lf = 32'h9248321f;
    do_reset(1'b1);
    i_lgt_sw_model.rd(LGT_ADDR_MODE, q);
    chk("mode_rst", 8'h67, q);
    i_lgt_sw_model.rd(LGT_ADDR_CLEAR, q);
    chk("clr_rd", 8'h9a, q);
    i_lgt_sw_model.wr(LGT_ADDR_MASK, 8'h07, 1'b0);
    i_lgt_sw_model.wr_mode(5'h08);
    i_lgt_sw_model.rd(LGT_ADDR_MODE, q);
    chk("mode_fixed", 8'h60, q);
    {halt_m, stop_m} <= 2'b11;
    i_lgt_sw_model.wr(LGT_ADDR_CLEAR, 8'hac, 1'b0);
    wait_req(40000);
    near("ovf_slow", 2048 * 8);
    @(posedge sys_clk);
    #1 chk("irq", 1'b1, irq);
    i_lgt_sw_model.rd(LGT_ADDR_STAT, q);
    chk("stat_ovf", 8'h01, q);
    i_lgt_sw_model.wr_mode(5'h07);
    #1 chk("mode2", 1'b1, req);
    i_lgt_sw_model.wr(LGT_ADDR_MODE, 8'h67, 1'b1);
    #1 chk("mode_bit", 1'b1, req);
    lf = lfsr(lf);
    i_lgt_sw_model.wr(LGT_ADDR_CLEAR, lf[7:0] ^ {7'h0, lf[7:0] == 8'hac}, 1'b0);
    #1 chk("badkey", 1'b1, req);
    i_lgt_sw_model.rd(LGT_ADDR_STAT, q);
    chk("stat_flt", 8'h06, q);
    i_lgt_sw_model.rd(LGT_ADDR_STAT, q);
    chk("stat_clr", 8'h00, q);
    chk("irq_clr", 1'b0, irq);
    $display("test unstoppable done");
    for (int c = 0; c < 2; c++) begin
      do_reset(1'b0);
      i_lgt_sw_model.wr_mode({2'b01, 3'(c)});
      wait_req(40000);
      e = 1 << (13 + c);
      near("ovf_sys", e);
      i_lgt_sw_model.wr(LGT_ADDR_CLEAR, 8'hac, 1'b0);
      repeat (3000) @(posedge sys_clk);
      if (c == 0) stop_m <= 1'b1;
      else halt_m <= 1'b1;
      repeat (1000) @(posedge sys_clk);
      {halt_m, stop_m} <= 2'b00;
      wait_req(60000);
      near("ovf_lowpow", e - 3000 + (c == 0 ? LGT_STOP_IDLE_CYC : 0));
    end
    $display("test stoppable done");
    for (int c = 0; c < 2; c++) begin
      do_reset(1'b0);
      i_lgt_sw_model.wr_mode(c == 0 ? 5'h17 : 5'h1f);
      repeat (3) begin
        lf = lfsr(lf);
        i_lgt_sw_model.wr(LGT_ADDR_CLEAR, lf[7:0] ^ {7'h0, lf[7:0] == 8'hac}, lf[8]);
        #1 chk("halted_key", 1'b0, req);
        i_lgt_sw_model.wr_mode(lf[13:9]);
        #1 chk("halted_mode", 1'b0, req);
      end
      wait_req(5000);
      chk("halted", 5000, n);
    end
    $display("test halted done");
    end_sim();
  end
  initial begin
    #2500000;
    err_total++;
    end_sim();
  end
endmodule : tb_lgt_loop_guard_timer
`default_nettype wire
